// [rtl/control_mode_config_select.sv]
`timescale 1ns/1ps
// How it works
// - Primary mode pin low selects extended, register-driven control.
// - Primary floating and strap not low, floating range pin selects extended.
// - Rate select from edge pin, or output_setup bit 10 in extended.
// - DDR phase zero in normal mode, output_setup bit 11 in extended.
// - Normal SDR: edge pin high means rising edge, low falling.
// - Extended SDR edge comes from output_setup bit 8.
// - Swing from swing pin, or output_setup bit 9 in extended.
// - Normal mode: delay pin low short delay, high long delay.
// - Normal mode: range pin picks normal or reduced for both channels.
// - Extended: per-channel nine-bit full scale from registers 3 and B.
// - Offset zero in normal; extended nine-bit codes from 2 and A.
// - Dual-edge from floating delay pin, or extended_setup bit 13.
// - Dual-edge input: I only in normal, selectable in extended.
// - Test pattern only in extended mode with extended_setup bit 15.
// - Extended clock-always-on bit keeps data clock running.
// - Extended DDR: bit 8 high non-demux, low 1:2 demux.
// - Extended: second clock replaces over-range when bit 13 low.
// - Phase adjust only extended: coarse F[15:7], fine E[15:8].
// - Power-on register values give the documented extended defaults.
// - Full scale of both channels starts at nominal code.
// - Serial word: header 001h, 4-bit address, 16 data bits, MSB first.
// - Register contents have no effect in normal mode.
module control_mode_config_select (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Mode straps, each three-level pin as level plus float
    input  wire logic        mode_pin_level,
    input  wire logic        mode_pin_float,
    input  wire logic        strap_pin_level,
    input  wire logic        strap_pin_float,
    input  wire logic        range_pin_level,
    input  wire logic        range_pin_float,
    // Normal mode control pins
    input  wire logic        edge_select_pin,
    input  wire logic        edge_select_float,
    input  wire logic        swing_select_pin,
    input  wire logic        delay_pin_level,
    input  wire logic        delay_pin_float,
    // Serial interface
    input  wire logic        serial_clk,
    input  wire logic        serial_data,
    input  wire logic        serial_sel_n,
    // Mode status
    output logic             mode_valid_q,
    output logic             extended_mode_q,
    // Output clocking
    output logic             single_rate_q,
    output logic             ddr_phase_sel_q,
    output logic             sdr_rising_edge_q,
    output logic             non_demux_q,
    output logic             swing_normal_q,
    output logic             clock_always_on_q,
    output logic             second_clock_q,
    // Sampling
    output logic             cal_delay_long_q,
    output logic             dual_edge_en_q,
    output logic             dual_edge_q_input_q,
    output logic             test_pattern_q,
    // Analog trims
    output logic             range_reduced_q,
    output logic [8:0]       full_scale_i_q,
    output logic [8:0]       full_scale_q_q,
    output logic [8:0]       offset_i_q,
    output logic [8:0]       offset_q_q,
    output logic             phase_adjust_en_q,
    output logic [8:0]       phase_coarse_q,
    output logic [7:0]       phase_fine_q
);
    localparam int CL = mode_cfg_pkg::CODE_LSB;
    localparam int CM = mode_cfg_pkg::CODE_MSB;
    localparam int FL = mode_cfg_pkg::FINE_LSB;
    localparam int FM = mode_cfg_pkg::FINE_MSB;

    // Register bank
    logic [15:0] output_setup_q;
    logic [15:0] i_channel_offset_q;
    logic [15:0] i_channel_full_scale_q;
    logic [15:0] extended_setup_q;
    logic [15:0] q_channel_offset_q;
    logic [15:0] q_channel_full_scale_q;
    logic [15:0] sample_phase_fine_q;
    logic [15:0] sample_phase_coarse_mid_q;

    // Serial decode
    logic        rx_wr;
    logic [3:0]  rx_addr;
    logic [15:0] rx_data;
    wire         serial_en = mode_valid_q & extended_mode_q;

    serial_word_rx u_rx (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .serial_clk   (serial_clk),
        .serial_data  (serial_data),
        .serial_sel_n (serial_sel_n),
        .enable       (serial_en),
        .wr_q         (rx_wr),
        .wr_addr_q    (rx_addr),
        .wr_data_q    (rx_data)
    );

    // Mode request from the straps
    wire strap_not_low = strap_pin_float | strap_pin_level;
    wire req_primary   = ~mode_pin_float & ~mode_pin_level;
    wire req_range     = mode_pin_float & strap_not_low
                       & range_pin_float;
    wire ext_request   = req_primary | req_range;

    // Straps are caught after release, never under reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_valid_q    <= 1'b0;
            extended_mode_q <= 1'b0;
        end else if (!mode_valid_q) begin
            mode_valid_q    <= 1'b1;
            extended_mode_q <= ext_request;
        end
    end

    // Writes land only in extended mode
    wire wr_ok   = rx_wr & serial_en;
    wire wr_oset = wr_ok & (rx_addr == mode_cfg_pkg::ADDR_OUTPUT_SETUP);
    wire wr_ioff = wr_ok & (rx_addr == mode_cfg_pkg::ADDR_I_OFFSET);
    wire wr_ifs  = wr_ok & (rx_addr == mode_cfg_pkg::ADDR_I_FULL_SCALE);
    wire wr_eset = wr_ok & (rx_addr == mode_cfg_pkg::ADDR_EXT_SETUP);
    wire wr_qoff = wr_ok & (rx_addr == mode_cfg_pkg::ADDR_Q_OFFSET);
    wire wr_qfs  = wr_ok & (rx_addr == mode_cfg_pkg::ADDR_Q_FULL_SCALE);
    wire wr_fine = wr_ok & (rx_addr == mode_cfg_pkg::ADDR_PHASE_FINE);
    wire wr_crs  = wr_ok & (rx_addr == mode_cfg_pkg::ADDR_PHASE_COARSE);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            output_setup_q            <= mode_cfg_pkg::OUTPUT_SETUP_RST;
            i_channel_offset_q        <= mode_cfg_pkg::OFFSET_RST;
            i_channel_full_scale_q    <= mode_cfg_pkg::FULL_SCALE_RST;
            extended_setup_q          <= mode_cfg_pkg::EXT_SETUP_RST;
            q_channel_offset_q        <= mode_cfg_pkg::OFFSET_RST;
            q_channel_full_scale_q    <= mode_cfg_pkg::FULL_SCALE_RST;
            sample_phase_fine_q       <= mode_cfg_pkg::PHASE_RST;
            sample_phase_coarse_mid_q <= mode_cfg_pkg::PHASE_RST;
        end else begin
            if (wr_oset) output_setup_q            <= rx_data;
            if (wr_ioff) i_channel_offset_q        <= rx_data;
            if (wr_ifs)  i_channel_full_scale_q    <= rx_data;
            if (wr_eset) extended_setup_q          <= rx_data;
            if (wr_qoff) q_channel_offset_q        <= rx_data;
            if (wr_qfs)  q_channel_full_scale_q    <= rx_data;
            if (wr_fine) sample_phase_fine_q       <= rx_data;
            if (wr_crs)  sample_phase_coarse_mid_q <= rx_data;
        end
    end

    // Register fields
    wire f_edge_demux = output_setup_q[mode_cfg_pkg::OSET_EDGE_DEMUX_BIT];
    wire f_swing      = output_setup_q[mode_cfg_pkg::OSET_SWING_BIT];
    wire f_rate       = output_setup_q[mode_cfg_pkg::OSET_RATE_BIT];
    wire f_phase      = output_setup_q[mode_cfg_pkg::OSET_PHASE_BIT];
    wire f_second_n   = output_setup_q[mode_cfg_pkg::OSET_SECOND_CLK_BIT];
    wire f_q_input    = extended_setup_q[mode_cfg_pkg::ESET_Q_INPUT_BIT];
    wire f_des        = extended_setup_q[mode_cfg_pkg::ESET_DES_BIT];
    wire f_trim_clk   = extended_setup_q[mode_cfg_pkg::ESET_TRIM_CLK_BIT];
    wire f_test       = extended_setup_q[mode_cfg_pkg::ESET_TEST_PAT_BIT];

    // Feature selection by the held mode
    wire ext = extended_mode_q;
    wire single_rate_d  = ext ? f_rate : ~edge_select_float;
    wire ddr_phase_d    = ext & f_phase;
    wire sdr_rising_d   = ext ? f_edge_demux
                              : edge_select_pin;
    // Edge bit doubles as demux choice only under DDR
    wire non_demux_d    = ext & ~f_rate & f_edge_demux;
    wire swing_d        = ext ? f_swing : swing_select_pin;
    wire clk_on_d       = ext & f_trim_clk;
    wire second_clk_d   = ext & ~f_second_n;
    // Extended delay has no control here, short is the default
    wire cal_long_d     = ~ext & ~delay_pin_float
                        & delay_pin_level;
    wire des_d          = ext ? f_des : delay_pin_float;
    wire des_q_d        = ext & f_des & f_q_input;
    wire test_d         = ext & f_test;
    wire reduced_d      = ~ext & ~range_pin_float
                        & ~range_pin_level;
    wire [8:0] fs_i_d   = ext ? i_channel_full_scale_q[CM:CL]
                              : mode_cfg_pkg::CODE_NOMINAL;
    wire [8:0] fs_q_d   = ext ? q_channel_full_scale_q[CM:CL]
                              : mode_cfg_pkg::CODE_NOMINAL;
    wire [8:0] off_i_d  = ext ? i_channel_offset_q[CM:CL]
                              : mode_cfg_pkg::CODE_ZERO;
    wire [8:0] off_q_d  = ext ? q_channel_offset_q[CM:CL]
                              : mode_cfg_pkg::CODE_ZERO;
    wire [8:0] crs_d    = ext ? sample_phase_coarse_mid_q[CM:CL]
                              : mode_cfg_pkg::CODE_ZERO;
    wire [7:0] fine_d   = ext ? sample_phase_fine_q[FM:FL]
                              : mode_cfg_pkg::FINE_ZERO;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            single_rate_q       <= 1'b0;
            ddr_phase_sel_q     <= 1'b0;
            sdr_rising_edge_q   <= 1'b0;
            non_demux_q         <= 1'b0;
            swing_normal_q      <= 1'b1;
            clock_always_on_q   <= 1'b0;
            second_clock_q      <= 1'b0;
            cal_delay_long_q    <= 1'b0;
            dual_edge_en_q      <= 1'b0;
            dual_edge_q_input_q <= 1'b0;
            test_pattern_q      <= 1'b0;
            range_reduced_q     <= 1'b0;
            full_scale_i_q      <= mode_cfg_pkg::CODE_NOMINAL;
            full_scale_q_q      <= mode_cfg_pkg::CODE_NOMINAL;
            offset_i_q          <= mode_cfg_pkg::CODE_ZERO;
            offset_q_q          <= mode_cfg_pkg::CODE_ZERO;
            phase_adjust_en_q   <= 1'b0;
            phase_coarse_q      <= mode_cfg_pkg::CODE_ZERO;
            phase_fine_q        <= mode_cfg_pkg::FINE_ZERO;
        end else if (mode_valid_q) begin
            single_rate_q       <= single_rate_d;
            ddr_phase_sel_q     <= ddr_phase_d;
            sdr_rising_edge_q   <= sdr_rising_d;
            non_demux_q         <= non_demux_d;
            swing_normal_q      <= swing_d;
            clock_always_on_q   <= clk_on_d;
            second_clock_q      <= second_clk_d;
            cal_delay_long_q    <= cal_long_d;
            dual_edge_en_q      <= des_d;
            dual_edge_q_input_q <= des_q_d;
            test_pattern_q      <= test_d;
            range_reduced_q     <= reduced_d;
            full_scale_i_q      <= fs_i_d;
            full_scale_q_q      <= fs_q_d;
            offset_i_q          <= off_i_d;
            offset_q_q          <= off_q_d;
            phase_adjust_en_q   <= ext;
            phase_coarse_q      <= crs_d;
            phase_fine_q        <= fine_d;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_mode_primary_low: assert property (
        !mode_valid_q && req_primary |=> mode_valid_q && extended_mode_q)
        else $error("primary pin low did not select extended mode");

    chk_mode_range_float: assert property (
        !mode_valid_q && !req_primary |=> extended_mode_q == $past(req_range))
        else $error("range pin float did not decide the mode");

    chk_mode_held: assert property (
        mode_valid_q |=> mode_valid_q && $stable(extended_mode_q))
        else $error("control mode changed while operating");

    chk_rate_from_reg: assert property (
        mode_valid_q && extended_mode_q |=>
            single_rate_q == $past(f_rate))
        else $error("rate select not taken from output_setup");

    chk_phase_zero_norm: assert property (
        mode_valid_q && !extended_mode_q |=> !ddr_phase_sel_q)
        else $error("DDR phase not zero in normal mode");

    chk_edge_from_pin: assert property (
        mode_valid_q && !extended_mode_q |=>
            sdr_rising_edge_q == $past(edge_select_pin))
        else $error("SDR edge does not follow the edge pin");

    chk_demux_ddr_only: assert property (
        non_demux_q |-> extended_mode_q && !single_rate_q)
        else $error("non-demux selected outside extended DDR");

    chk_offset_normal: assert property (
        mode_valid_q && !extended_mode_q |=> offset_i_q == 9'h000
            && offset_q_q == 9'h000 && !phase_adjust_en_q)
        else $error("offset or phase adjust active in normal mode");

    chk_test_pat_ext: assert property (
        test_pattern_q |-> extended_mode_q)
        else $error("test pattern driven in normal mode");

    chk_normal_no_write: assert property (
        mode_valid_q && !extended_mode_q |=>
            $stable(output_setup_q) && $stable(extended_setup_q))
        else $error("register changed in normal mode");

    chk_write_lands: assert property (
        wr_oset |=> output_setup_q == $past(rx_data))
        else $error("output_setup write was lost");

    chk_phase_from_reg: assert property (
        mode_valid_q && extended_mode_q |=> ddr_phase_sel_q == $past(f_phase))
        else $error("DDR phase not taken from register");

    chk_edge_from_reg: assert property (
        mode_valid_q && extended_mode_q |=>
            sdr_rising_edge_q == $past(f_edge_demux))
        else $error("SDR edge not taken from register");

    chk_demux_from_reg: assert property (
        mode_valid_q && extended_mode_q && !f_rate |=>
            non_demux_q == $past(f_edge_demux))
        else $error("demux choice not taken from register");

    chk_swing_select: assert property (
        mode_valid_q |=> swing_normal_q ==
            $past(extended_mode_q ? f_swing : swing_select_pin))
        else $error("swing follows neither pin nor field");

    chk_cal_delay_pin: assert property (
        mode_valid_q && !extended_mode_q |=>
            cal_delay_long_q == $past(delay_pin_level && !delay_pin_float))
        else $error("calibration delay ignores its pin");

    chk_range_both_ch: assert property (
        mode_valid_q && !extended_mode_q |=> full_scale_i_q == full_scale_q_q
            && range_reduced_q == $past(!range_pin_float && !range_pin_level))
        else $error("range pin not applied to both channels");

    chk_dual_edge_pin: assert property (
        mode_valid_q && !extended_mode_q |=>
            dual_edge_en_q == $past(delay_pin_float) && !dual_edge_q_input_q)
        else $error("dual-edge setting wrong in normal mode");

    chk_clock_opts: assert property (
        mode_valid_q && extended_mode_q |=>
            second_clock_q != $past(f_second_n)
            && clock_always_on_q == $past(f_trim_clk))
        else $error("clock options not taken from registers");

    chk_phase_adjust: assert property (
        mode_valid_q && extended_mode_q |=> phase_adjust_en_q
            && phase_fine_q == $past(sample_phase_fine_q[FM:FL]))
        else $error("fine phase not taken from register");

    chk_power_on_vals: assert property (
        !mode_valid_q |-> output_setup_q == mode_cfg_pkg::OUTPUT_SETUP_RST
            && full_scale_i_q == mode_cfg_pkg::CODE_NOMINAL
            && full_scale_q_q == mode_cfg_pkg::CODE_NOMINAL)
        else $error("power-on values not in place");

    chk_test_from_reg: assert property (
        mode_valid_q && extended_mode_q |=> test_pattern_q == $past(f_test))
        else $error("test pattern not taken from register");

endmodule : control_mode_config_select

// [rtl/mode_cfg_pkg.sv]
package mode_cfg_pkg;

    // Register addresses of the serial map
    localparam logic [3:0] ADDR_OUTPUT_SETUP   = 4'h1;
    localparam logic [3:0] ADDR_I_OFFSET       = 4'h2;
    localparam logic [3:0] ADDR_I_FULL_SCALE   = 4'h3;
    localparam logic [3:0] ADDR_EXT_SETUP      = 4'h9;
    localparam logic [3:0] ADDR_Q_OFFSET       = 4'hA;
    localparam logic [3:0] ADDR_Q_FULL_SCALE   = 4'hB;
    localparam logic [3:0] ADDR_PHASE_FINE     = 4'hE;
    localparam logic [3:0] ADDR_PHASE_COARSE   = 4'hF;

    // Serial word layout
    localparam int          WORD_BITS   = 32;
    localparam int          HDR_BITS    = 12;
    localparam logic [11:0] WORD_HEADER = 12'h001;

    // Field positions in output_setup
    localparam int OSET_EDGE_DEMUX_BIT = 8;
    localparam int OSET_SWING_BIT      = 9;
    localparam int OSET_RATE_BIT       = 10;
    localparam int OSET_PHASE_BIT      = 11;
    localparam int OSET_SECOND_CLK_BIT = 13;

    // Field positions in extended_setup
    localparam int ESET_Q_INPUT_BIT    = 12;
    localparam int ESET_DES_BIT        = 13;
    localparam int ESET_TRIM_CLK_BIT   = 14;
    localparam int ESET_TEST_PAT_BIT   = 15;

    // Nine-bit code fields and the eight-bit fine phase field
    localparam int CODE_LSB            = 7;
    localparam int CODE_MSB            = 15;
    localparam int FINE_LSB            = 8;
    localparam int FINE_MSB            = 15;

    // Power-on values
    localparam logic [15:0] OUTPUT_SETUP_RST = 16'hB2FF;
    localparam logic [15:0] EXT_SETUP_RST    = 16'h007F;
    localparam logic [15:0] FULL_SCALE_RST   = 16'h807F;
    localparam logic [15:0] OFFSET_RST       = 16'h007F;
    localparam logic [15:0] PHASE_RST        = 16'h007F;
    localparam logic [8:0]  CODE_NOMINAL     = 9'h100;
    localparam logic [8:0]  CODE_ZERO        = 9'h000;
    localparam logic [7:0]  FINE_ZERO        = 8'h00;

endpackage : mode_cfg_pkg

// [rtl/serial_word_rx.sv]
`timescale 1ns/1ps
module serial_word_rx (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Serial pins, already synchronous to ref_clk
    input  wire logic        serial_clk,
    input  wire logic        serial_data,
    input  wire logic        serial_sel_n,
    input  wire logic        enable,
    // Decoded write
    output logic             wr_q,
    output logic [3:0]       wr_addr_q,
    output logic [15:0]      wr_data_q
);
    logic        sclk_q;
    logic [4:0]  count_q;
    logic [30:0] shift_q;
    wire         rise       = serial_clk & ~sclk_q & ~serial_sel_n & enable;
    wire         last_bit   = (count_q == 5'(mode_cfg_pkg::WORD_BITS - 1));
    wire  [31:0] word       = {shift_q, serial_data};
    wire         header_ok  =
        (word[31:32-mode_cfg_pkg::HDR_BITS] == mode_cfg_pkg::WORD_HEADER);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sclk_q  <= 1'b0;
            count_q <= 5'h00;
            shift_q <= 31'h0;
        end else begin
            sclk_q <= serial_clk;
            // Deselect aborts a partial word
            if (serial_sel_n || !enable) begin
                count_q <= 5'h00;
            end else if (rise) begin
                // Wraps to zero so the next word starts at once
                count_q <= count_q + 5'h01;
                shift_q <= {shift_q[29:0], serial_data};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_q      <= 1'b0;
            wr_addr_q <= 4'h0;
            wr_data_q <= 16'h0000;
        end else begin
            wr_q <= rise & last_bit & header_ok;
            if (rise && last_bit) begin
                wr_addr_q <= word[19:16];
                wr_data_q <= word[15:0];
            end
        end
    end

endmodule : serial_word_rx

// [tb/control_mode_config_select_tb_top.sv]
`timescale 1ns/1ps
module control_mode_config_select_tb_top;
    logic ref_clk = 1'b0, srst = 1'b1, go = 1'b0, slow = 1'b0, busy;
    logic mode_pin_level = 1'b1, mode_pin_float = 1'b0;
    logic strap_pin_level = 1'b1, strap_pin_float = 1'b0;
    logic range_pin_level = 1'b0, range_pin_float = 1'b0;
    logic edge_select_pin = 1'b1, edge_select_float = 1'b0;
    logic swing_select_pin = 1'b0;
    logic delay_pin_level = 1'b1, delay_pin_float = 1'b0;
    logic serial_clk, serial_data, serial_sel_n;
    logic [31:0] word = '0;
    logic mode_valid_q, extended_mode_q, single_rate_q, ddr_phase_sel_q;
    logic sdr_rising_edge_q, non_demux_q, swing_normal_q, clock_always_on_q;
    logic second_clock_q, cal_delay_long_q, dual_edge_en_q;
    logic dual_edge_q_input_q, test_pattern_q, range_reduced_q;
    logic [8:0] full_scale_i_q, full_scale_q_q, offset_i_q, offset_q_q;
    logic phase_adjust_en_q;
    logic [8:0] phase_coarse_q;
    logic [7:0] phase_fine_q;
    int errors = 0, samples_checked = 0, cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    control_mode_config_select dut_u (.ref_clk, .srst, .mode_pin_level,
        .mode_pin_float, .strap_pin_level, .strap_pin_float,
        .range_pin_level, .range_pin_float, .edge_select_pin,
        .edge_select_float, .swing_select_pin, .delay_pin_level,
        .delay_pin_float, .serial_clk, .serial_data, .serial_sel_n,
        .mode_valid_q, .extended_mode_q, .single_rate_q, .ddr_phase_sel_q,
        .sdr_rising_edge_q, .non_demux_q, .swing_normal_q,
        .clock_always_on_q, .second_clock_q, .cal_delay_long_q,
        .dual_edge_en_q, .dual_edge_q_input_q, .test_pattern_q,
        .range_reduced_q, .full_scale_i_q, .full_scale_q_q, .offset_i_q,
        .offset_q_q, .phase_adjust_en_q, .phase_coarse_q, .phase_fine_q);

    serial_host_model host_u (.ref_clk, .go, .slow, .word, .busy,
        .serial_clk, .serial_data, .serial_sel_n);

    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Straps are set under reset here and stay put across release
    task automatic do_reset(input logic [5:0] s);
        @(negedge ref_clk);
        srst <= 1'b1;
        {mode_pin_level, mode_pin_float, strap_pin_level, strap_pin_float,
         range_pin_level, range_pin_float} <= s;
        repeat (8) @(negedge ref_clk);
        srst <= 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : do_reset

    task automatic send(input logic [3:0] a, input logic [15:0] d,
                        input logic s = 1'b0, input logic [11:0] h = 12'h001);
        int n;
        @(negedge ref_clk);
        go <= 1'b1;
        slow <= s;
        word <= {h, a, d};
        @(negedge ref_clk);
        go <= 1'b0;
        @(negedge ref_clk);
        for (n = 0; n < 400 && busy === 1'b1; n++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
    endtask : send

    task automatic test_mode_select();
        logic [5:0] cases [6] = '{6'h0A, 6'h2A, 6'h15, 6'h19, 6'h11, 6'h1A};
        logic       exp [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 6; i++) begin
            do_reset(cases[i]);
            cmp(mode_valid_q, 9'h001);
            cmp(extended_mode_q, {8'h00, exp[i]});
        end
    endtask : test_mode_select

    task automatic test_normal();
        do_reset(6'h28);
        cmp(single_rate_q, 9'h001);
        cmp(sdr_rising_edge_q, 9'h001);
        cmp(swing_normal_q, 9'h000);
        cmp(cal_delay_long_q, 9'h001);
        cmp(range_reduced_q, 9'h001);
        cmp(full_scale_i_q, 9'h100);
        send(4'h9, 16'hF07F);
        send(4'h1, 16'h99FF);
        send(4'h2, 16'hAA80);
        edge_select_pin <= 1'b0;
        swing_select_pin <= 1'b1;
        delay_pin_float <= 1'b1;
        range_pin_level <= 1'b1;
        mode_pin_level <= 1'b0;
        repeat (2) @(negedge ref_clk);
        cmp(extended_mode_q, 9'h000);
        cmp(sdr_rising_edge_q, 9'h000);
        cmp(swing_normal_q, 9'h001);
        cmp(dual_edge_en_q, 9'h001);
        cmp(dual_edge_q_input_q, 9'h000);
        cmp(range_reduced_q, 9'h000);
        cmp(test_pattern_q, 9'h000);
        cmp(second_clock_q, 9'h000);
        cmp(clock_always_on_q, 9'h000);
        cmp(offset_i_q, 9'h000);
        cmp(phase_adjust_en_q, 9'h000);
        edge_select_float <= 1'b1;
        delay_pin_float <= 1'b0;
        delay_pin_level <= 1'b0;
        repeat (2) @(negedge ref_clk);
        cmp(single_rate_q, 9'h000);
        cmp(ddr_phase_sel_q, 9'h000);
        cmp(non_demux_q, 9'h000);
        cmp(cal_delay_long_q, 9'h000);
        edge_select_float <= 1'b0;
    endtask : test_normal

    task automatic test_extended();
        do_reset(6'h0A);
        cmp(single_rate_q, 9'h000);
        cmp(ddr_phase_sel_q, 9'h000);
        cmp(swing_normal_q, 9'h001);
        cmp(cal_delay_long_q, 9'h000);
        cmp(offset_q_q, 9'h000);
        cmp(dual_edge_en_q, 9'h000);
        cmp(test_pattern_q, 9'h000);
        cmp(clock_always_on_q, 9'h000);
        cmp(non_demux_q, 9'h000);
        cmp(second_clock_q, 9'h000);
        cmp({1'b0, phase_fine_q}, 9'h000);
        cmp(phase_coarse_q, 9'h000);
        cmp(full_scale_i_q, 9'h100);
        cmp(full_scale_q_q, 9'h100);
        send(4'h1, 16'h99FF);
        cmp(second_clock_q, 9'h001);
        cmp(ddr_phase_sel_q, 9'h001);
        cmp(non_demux_q, 9'h001);
        cmp(swing_normal_q, 9'h000);
        send(4'h1, 16'h86FF, 1'b1);
        cmp(single_rate_q, 9'h001);
        cmp(sdr_rising_edge_q, 9'h000);
        send(4'h9, 16'hF07F, 1'b1);
        cmp(test_pattern_q, 9'h001);
        cmp(clock_always_on_q, 9'h001);
        cmp(dual_edge_en_q, 9'h001);
        cmp(dual_edge_q_input_q, 9'h001);
        send(4'h3, 16'hFF80);
        send(4'hB, 16'h0080);
        send(4'h2, 16'hAA80);
        send(4'hA, 16'h5500);
        send(4'hF, 16'h9180);
        send(4'hE, 16'hA500);
        cmp(full_scale_i_q, 9'h1FF);
        cmp(full_scale_q_q, 9'h001);
        cmp(offset_i_q, 9'h155);
        cmp(offset_q_q, 9'h0AA);
        cmp(phase_coarse_q, 9'h123);
        cmp({1'b0, phase_fine_q}, 9'h0A5);
        cmp(phase_adjust_en_q, 9'h001);
        send(4'h1, 16'h99FF, 1'b0, 12'h002);
        send(4'h7, 16'h0000);
        cmp(single_rate_q, 9'h001);
        cmp(full_scale_i_q, 9'h1FF);
    endtask : test_extended

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        test_mode_select();
        test_normal();
        test_extended();
        give_verdict();
    end
endmodule : control_mode_config_select_tb_top

// [tb/serial_host_model.sv]
`timescale 1ns/1ps
module serial_host_model (
    // Clock
    input  wire logic        ref_clk,
    // Command from the bench
    input  wire logic        go,
    input  wire logic        slow,
    input  wire logic [31:0] word,
    output logic             busy,
    // Serial pins
    output logic             serial_clk,
    output logic             serial_data,
    output logic             serial_sel_n
);
    logic [31:0] shift_q;
    logic [5:0]  bits_left;
    logic [1:0]  hold_cnt;
    initial begin
        busy = 1'b0;
        serial_clk = 1'b0;
        serial_data = 1'b0;
        serial_sel_n = 1'b1;
        shift_q = '0;
        bits_left = '0;
        hold_cnt = '0;
    end
    // Pins move on the falling edge, clear of the sampling edge
    always @(negedge ref_clk) begin
        if (!busy) begin
            if (go) begin
                busy <= 1'b1;
                serial_sel_n <= 1'b0;
                serial_data <= word[31];
                shift_q <= word << 1;
                bits_left <= 6'h20;
                hold_cnt <= slow ? 2'h2 : 2'h0;
            end else begin
                // Released line has no pull, so it keeps toggling
                serial_data <= ~serial_data;
            end
        end else if (hold_cnt != 2'h0) begin
            hold_cnt <= hold_cnt - 2'h1;
        end else if (!serial_clk) begin
            serial_clk <= 1'b1;
            hold_cnt <= slow ? 2'h2 : 2'h0;
        end else begin
            serial_clk <= 1'b0;
            bits_left <= bits_left - 6'h1;
            hold_cnt <= slow ? 2'h2 : 2'h0;
            if (bits_left == 6'h1) begin
                busy <= 1'b0;
                serial_sel_n <= 1'b1;
                serial_data <= ~serial_data;
            end else begin
                serial_data <= shift_q[31];
                shift_q <= shift_q << 1;
            end
        end
    end
endmodule : serial_host_model
